// >>> rtl/wdm_pkg.sv
// Package: constants, types and helpers of the watchdog mode control block
package wdm_pkg;

  // Location of the mode register in the expanded register file
  localparam logic [3:0] MODE_REG_BANK = 4'hf;
  localparam logic [7:0] MODE_REG_ADDR = 8'h0f;

  // Field positions inside the mode register
  localparam int TAP_LSB = 0;
  localparam int TAP_MSB = 1;
  localparam int HALT_BIT = 2;
  localparam int STOP_BIT = 3;
  localparam int SRC_BIT = 4;

  // Reset values of the mode fields
  localparam logic [1:0] TAP_RST = 2'h1;
  localparam logic HALT_RST = 1'b1;
  localparam logic STOP_RST = 1'b1;
  localparam logic SRC_RST = 1'b0;

  // Write window length in processor cycles
  localparam logic [6:0] WIN_CYCLES = 7'h40;

  // Time-out taps on the internal oscillator, in ms
  localparam int TAP0_MS = 5;
  localparam int TAP1_MS = 15;
  localparam int TAP2_MS = 25;
  localparam int TAP3_MS = 100;

  // Time-out taps on the RC clock, in clock periods
  localparam logic [23:0] TAP0_RC = 24'h000200;
  localparam logic [23:0] TAP1_RC = 24'h000400;
  localparam logic [23:0] TAP2_RC = 24'h000800;
  localparam logic [23:0] TAP3_RC = 24'h002000;

  // Power-on hold when the time base is the default core clock
  localparam int CLK_MHZ = 250;
  localparam int POR_HOLD_MS = 1500;
  localparam int unsigned POR_HOLD_CYC =
    32'(64'(POR_HOLD_MS) * 64'd1000 * 64'(CLK_MHZ));

  // Width of the watchdog and recovery counter chain
  localparam int CNT_W = 24;

  typedef enum logic [1:0] {
    ST_POR_HOLD = 2'b00,
    ST_RECOVER = 2'b01,
    ST_RUN = 2'b10
  } wdm_state_e;

  typedef struct packed {
    logic src;
    logic stop_act;
    logic halt_act;
    logic [1:0] tap;
  } wdm_mode_s;

  typedef struct packed {
    logic en;
    logic [3:0] bank;
    logic [7:0] addr;
    logic [7:0] data;
  } wdm_wr_s;

  typedef struct packed {
    logic [CNT_W-1:0] value;
  } wdm_cnt_s;

  typedef struct packed {
    wdm_state_e state;
    wdm_mode_s mode;
    logic [6:0] win_cnt;
    logic wdt_on;
    logic [31:0] hold_cnt;
    logic [2:0] rc_sync;
    logic [2:0] osc_sync;
    logic [1:0] vcc_sync;
    logic core_reset;
    logic timeout;
    logic rc_only_stop;
    logic win_open;
    logic [7:0] rd_data;
  } wdm_top_s;

  // Terminal count of a tap for the selected source
  function automatic logic [CNT_W-1:0] tap_limit(input logic [1:0] tap,
                                                 input logic src,
                                                 input logic [15:0] khz);
    logic [CNT_W-1:0] lim;
    lim = TAP0_RC;
    case (tap)
      2'h0: lim = src ? TAP0_RC : CNT_W'(TAP0_MS * int'(khz));
      2'h1: lim = src ? TAP1_RC : CNT_W'(TAP1_MS * int'(khz));
      2'h2: lim = src ? TAP2_RC : CNT_W'(TAP2_MS * int'(khz));
      default: lim = src ? TAP3_RC : CNT_W'(TAP3_MS * int'(khz));
    endcase
    return lim;
  endfunction

endpackage

// >>> rtl/wdm_counter.sv
// Shared watchdog and recovery counter chain
`timescale 1ns/1ps
`default_nettype none
module wdm_counter (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic inc,
  output logic [wdm_pkg::CNT_W-1:0] count
);

  wdm_pkg::wdm_cnt_s cur_ff;
  wdm_pkg::wdm_cnt_s nxt_cnt;

  // Clear beats increment so a restart always starts at zero
  always_comb begin
    nxt_cnt = cur_ff;
    if (clr) begin
      nxt_cnt.value = '0;
    end else if (inc) begin
      nxt_cnt.value = cur_ff.value + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cnt;
    end
  end

  assign count = cur_ff.value;

endmodule // wdm_counter
`default_nettype wire

// >>> rtl/wdm_top.sv
// Watchdog mode register, watchdog timer and reset timing
// Behaviour
// - Tap field picks time-out per clock source
// - HALT-activity bit keeps counting, resets to one
// - STOP-activity bit keeps counting, resets to one
// - STOP-activity and source bits set: RC clocks only watchdog
// - Source bit selects RC for watchdog and recovery timing
// - Writes accepted only in 64-cycle window
// - Mode register at 0FH bank F, write-only
// - Bits five to seven ignored
// - Low supply holds global reset
// - Time-base default holds first instruction 1.5 s
// - Retriggerable one-shot, terminal count resets core
// - Chain never clocked from time base
`timescale 1ns/1ps
`default_nettype none
module wdm_top #(
  parameter logic TIME_BASE_DEFAULT = 1'b0,
  parameter logic [15:0] WDT_OSC_KHZ = 16'h0080,
  parameter int unsigned POR_HOLD_CYCLES = wdm_pkg::POR_HOLD_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire wdm_pkg::wdm_wr_s wr,
  input wire logic rd_en,
  input wire logic cpu_cycle,
  input wire logic wdt_instr,
  input wire logic halt_mode,
  input wire logic stop_mode,
  input wire logic stop_wake,
  input wire logic rc_clk_pin,
  input wire logic wdt_osc_pin,
  input wire logic vcc_low_pin,
  output logic core_reset,
  output logic wdt_timeout,
  output logic rc_only_in_stop,
  output logic wr_window_open,
  output logic [7:0] rd_data
);

  localparam wdm_pkg::wdm_state_e START_ST =
    TIME_BASE_DEFAULT ? wdm_pkg::ST_POR_HOLD : wdm_pkg::ST_RECOVER;

  localparam wdm_pkg::wdm_mode_s MODE_RST = '{
    src: wdm_pkg::SRC_RST,
    stop_act: wdm_pkg::STOP_RST,
    halt_act: wdm_pkg::HALT_RST,
    tap: wdm_pkg::TAP_RST
  };

  localparam wdm_pkg::wdm_top_s TOP_RST = '{
    state: START_ST,
    mode: MODE_RST,
    win_cnt: 7'h00,
    wdt_on: 1'b0,
    hold_cnt: 32'h0000_0000,
    rc_sync: 3'h0,
    osc_sync: 3'h0,
    vcc_sync: 2'h0,
    core_reset: 1'b1,
    timeout: 1'b0,
    rc_only_stop: 1'b0,
    win_open: 1'b0,
    rd_data: 8'h00
  };

  wdm_pkg::wdm_top_s cur_ff;
  wdm_pkg::wdm_top_s nxt_top;
  logic [wdm_pkg::CNT_W-1:0] cnt;
  logic cnt_clr;
  logic cnt_inc;
  logic rc_tick;
  logic osc_tick;
  logic src_tick;
  logic run_ok;
  logic reg_hit;
  logic [wdm_pkg::CNT_W-1:0] wdt_lim;
  logic [wdm_pkg::CNT_W-1:0] rec_lim;

  // One chain serves both recovery timing and the watchdog
  wdm_counter u_chain (
    .ref_clk(ref_clk),
    .rst(rst),
    .clr(cnt_clr),
    .inc(cnt_inc),
    .count(cnt)
  );

  // Next-state logic for the whole block
  always_comb begin
    nxt_top = cur_ff;
    cnt_clr = 1'b0;
    cnt_inc = 1'b0;
    // Clock pins pass three flops, supply pin two; edge taken from the second and third
    nxt_top.rc_sync = {cur_ff.rc_sync[1:0], rc_clk_pin};
    nxt_top.osc_sync = {cur_ff.osc_sync[1:0], wdt_osc_pin};
    nxt_top.vcc_sync = {cur_ff.vcc_sync[0], vcc_low_pin};
    rc_tick = cur_ff.rc_sync[1] & ~cur_ff.rc_sync[2];
    osc_tick = cur_ff.osc_sync[1] & ~cur_ff.osc_sync[2];
    // Only the oscillator or RC may clock the chain
    src_tick = cur_ff.mode.src ? rc_tick : osc_tick;
    run_ok = ~(halt_mode & ~cur_ff.mode.halt_act) &
             ~(stop_mode & ~cur_ff.mode.stop_act);
    wdt_lim = wdm_pkg::tap_limit(cur_ff.mode.tap, cur_ff.mode.src,
                                 WDT_OSC_KHZ);
    rec_lim = wdm_pkg::tap_limit(2'h0, cur_ff.mode.src, WDT_OSC_KHZ);
    reg_hit = wr.en && wr.bank == wdm_pkg::MODE_REG_BANK &&
              wr.addr == wdm_pkg::MODE_REG_ADDR;
    nxt_top.timeout = 1'b0;
    case (cur_ff.state)
      wdm_pkg::ST_POR_HOLD: begin
        cnt_clr = 1'b1;
        // Counted on the core clock, not on the chain
        if (cur_ff.hold_cnt >= 32'(POR_HOLD_CYCLES - 1)) begin
          nxt_top.state = wdm_pkg::ST_RUN;
          nxt_top.hold_cnt = 32'h0000_0000;
        end else begin
          nxt_top.hold_cnt = cur_ff.hold_cnt + 32'h0000_0001;
        end
      end
      wdm_pkg::ST_RECOVER: begin
        cnt_inc = src_tick;
        if (src_tick && cnt >= rec_lim - 1'b1) begin
          nxt_top.state = wdm_pkg::ST_RUN;
          cnt_clr = 1'b1;
        end
      end
      wdm_pkg::ST_RUN: begin
        // Window counts processor cycles from the first instruction
        if (cpu_cycle && cur_ff.win_cnt < wdm_pkg::WIN_CYCLES) begin
          nxt_top.win_cnt = cur_ff.win_cnt + 7'h01;
        end
        if (reg_hit && cur_ff.win_open) begin
          // Upper bits dropped, they steer nothing
          nxt_top.mode.tap = wr.data[wdm_pkg::TAP_MSB:wdm_pkg::TAP_LSB];
          nxt_top.mode.halt_act = wr.data[wdm_pkg::HALT_BIT];
          nxt_top.mode.stop_act = wr.data[wdm_pkg::STOP_BIT];
          nxt_top.mode.src = wr.data[wdm_pkg::SRC_BIT];
        end
        cnt_inc = cur_ff.wdt_on & src_tick & run_ok;
        if (wdt_instr) begin
          // Start or restart; wins over a same-cycle terminal count
          nxt_top.wdt_on = 1'b1;
          cnt_clr = 1'b1;
        end else if (cnt_inc && cnt >= wdt_lim - 1'b1) begin
          nxt_top.state = wdm_pkg::ST_RECOVER;
          nxt_top.wdt_on = 1'b0;
          nxt_top.mode = MODE_RST;
          nxt_top.timeout = 1'b1;
          cnt_clr = 1'b1;
        end
      end
      default: begin
        nxt_top.state = wdm_pkg::ST_RECOVER;
        cnt_clr = 1'b1;
      end
    endcase
    // Stop recovery restarts timing but keeps the mode settings
    if (stop_wake) begin
      nxt_top.state = wdm_pkg::ST_RECOVER;
      nxt_top.wdt_on = 1'b0;
      cnt_clr = 1'b1;
    end
    // Low supply re-enters recovery every cycle it lasts
    if (cur_ff.vcc_sync[1]) begin
      nxt_top.state = wdm_pkg::ST_RECOVER;
      nxt_top.wdt_on = 1'b0;
      cnt_clr = 1'b1;
    end
    if (nxt_top.state != wdm_pkg::ST_RUN) begin
      nxt_top.win_cnt = 7'h00;
    end
    nxt_top.core_reset = nxt_top.state != wdm_pkg::ST_RUN;
    nxt_top.win_open = nxt_top.state == wdm_pkg::ST_RUN &&
                       nxt_top.win_cnt < wdm_pkg::WIN_CYCLES;
    // Gates the RC clock to the watchdog alone while stopped
    nxt_top.rc_only_stop = stop_mode & nxt_top.mode.stop_act &
                           nxt_top.mode.src;
    // Register never returns its contents
    nxt_top.rd_data = rd_en ? 8'h00 : 8'h00;
  end

  // Single state register; reset covers power-on
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur_ff <= TOP_RST;
    end else begin
      cur_ff <= nxt_top;
    end
  end

  assign core_reset = cur_ff.core_reset;
  assign wdt_timeout = cur_ff.timeout;
  assign rc_only_in_stop = cur_ff.rc_only_stop;
  assign wr_window_open = cur_ff.win_open;
  assign rd_data = cur_ff.rd_data;

endmodule // wdm_top
`default_nettype wire

// >>> dv/wdm_top_asserts.sv
// Checker for the watchdog mode control ports
`timescale 1ns/1ps
`default_nettype none
module wdm_top_asserts (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cpu_cycle,
  input wire logic stop_mode,
  input wire logic vcc_low_pin,
  input wire logic core_reset,
  input wire logic wdt_timeout,
  input wire logic rc_only_in_stop,
  input wire logic wr_window_open,
  input wire logic [7:0] rd_data
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [7:0] pulses_ff;
  // Pulses seen while the window stays open
  always_ff @(posedge ref_clk)
    pulses_ff <= wr_window_open ? pulses_ff + 8'(cpu_cycle) : 8'h00;
  a_read_zero: assert property (rd_data == 8'h00)
    else $error("mode register read returned data");
  a_timeout_resets: assert property (wdt_timeout |->
    ##[0:1] core_reset)
    else $error("terminal count did not reset core");
  a_timeout_pulse: assert property (wdt_timeout |=> !wdt_timeout)
    else $error("timeout longer than one cycle");
  a_low_vcc_reset: assert property (vcc_low_pin [*4] |-> core_reset)
    else $error("low supply without reset");
  a_rc_only_stop: assert property (!stop_mode |=> !rc_only_in_stop)
    else $error("rc only flag outside stop");
  a_window_reset: assert property (core_reset |-> !wr_window_open)
    else $error("window open during reset");
  a_window_opens: assert property ($fell(core_reset) |->
    wr_window_open)
    else $error("window not opened after reset");
  a_window_long: assert property (pulses_ff <= 8'h41)
    else $error("window open too long");
  a_window_short: assert property (
    $fell(wr_window_open) && !core_reset |-> pulses_ff >= 8'h40)
    else $error("window closed early");
  c_timeout: cover property (wdt_timeout);
  c_close: cover property ($fell(wr_window_open) && !core_reset);
  c_rc_only: cover property (rc_only_in_stop);
endmodule // wdm_top_asserts
bind wdm_top wdm_top_asserts chk_u (.ref_clk, .rst, .cpu_cycle,
  .stop_mode, .vcc_low_pin, .core_reset, .wdt_timeout,
  .rc_only_in_stop, .wr_window_open, .rd_data);
`default_nettype wire

// >>> dv/wdm_top_tb.sv
// Self-checking bench for the watchdog mode control block
`timescale 1ns/1ps
`default_nettype none
module wdm_top_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  wdm_pkg::wdm_wr_s wr = '0;
  logic rd_en = 1'b0, cpu_cycle = 1'b0, cpu_on = 1'b0, wdt_instr = 1'b0;
  logic halt_mode = 1'b0, stop_mode = 1'b0, stop_wake = 1'b0;
  logic rc_clk_pin = 1'b0, wdt_osc_pin = 1'b0, vcc_low_pin = 1'b0;
  logic core_reset, wdt_timeout, rc_only_in_stop, wr_window_open;
  logic [7:0] rd_data;
  logic hold_core_reset;
  logic [2:0] div = 3'h0;
  int fail_count = 0, total_checks = 0;
  wdm_top #(.WDT_OSC_KHZ(16'h0001), .POR_HOLD_CYCLES(20)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .wr(wr), .rd_en(rd_en),
    .cpu_cycle(cpu_cycle), .wdt_instr(wdt_instr), .halt_mode(halt_mode),
    .stop_mode(stop_mode), .stop_wake(stop_wake), .rc_clk_pin(rc_clk_pin),
    .wdt_osc_pin(wdt_osc_pin), .vcc_low_pin(vcc_low_pin),
    .core_reset(core_reset), .wdt_timeout(wdt_timeout),
    .rc_only_in_stop(rc_only_in_stop), .wr_window_open(wr_window_open),
    .rd_data(rd_data));
  // Second copy boots on the time base to show the power-on hold
  wdm_top #(.TIME_BASE_DEFAULT(1'b1), .WDT_OSC_KHZ(16'h0001),
    .POR_HOLD_CYCLES(20)) dut_hold_u (
    .ref_clk(ref_clk), .rst(rst), .wr(wr), .rd_en(rd_en),
    .cpu_cycle(cpu_cycle), .wdt_instr(wdt_instr), .halt_mode(halt_mode),
    .stop_mode(stop_mode), .stop_wake(stop_wake), .rc_clk_pin(rc_clk_pin),
    .wdt_osc_pin(wdt_osc_pin), .vcc_low_pin(vcc_low_pin),
    .core_reset(hold_core_reset), .wdt_timeout(), .rc_only_in_stop(),
    .wr_window_open(), .rd_data());
  always #2 ref_clk = ~ref_clk;
  // Both source pins free-run at one eighth of ref_clk
  always @(posedge ref_clk) begin
    div <= div + 3'h1;
    rc_clk_pin <= div[2];
    wdt_osc_pin <= div[2];
    cpu_cycle <= cpu_on & ~cpu_cycle;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic stop_test();
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Bounded wait for the recovery to let the core run
  task automatic wait_run();
    for (int i = 0; i < 6000 && core_reset !== 1'b0; i++) cyc(1);
    check(core_reset, 1'b0);
  endtask
  task automatic wr_mode(input logic [3:0] bank, input logic [7:0] d);
    wr <= '{1'b1, bank, 8'h0f, d};
    cyc(1);
    wr.en <= 1'b0;
  endtask
  // Stop flag probe shows the source and stop bits
  task automatic probe(input logic e);
    stop_mode <= 1'b1;
    cyc(3);
    check(rc_only_in_stop, e);
    stop_mode <= 1'b0;
    cyc(1);
  endtask
  task automatic t_window();
    wait_run();
    check(wr_window_open, 1'b1);
    rd_en <= 1'b1;
    cyc(2);
    check(rd_data, 8'h00);
    rd_en <= 1'b0;
    wr_mode(4'he, 8'h18);
    probe(1'b0);
    wr_mode(4'hf, 8'hf8);
    probe(1'b1);
  endtask
  task automatic t_lock();
    cpu_on <= 1'b1;
    cyc(140);
    check(wr_window_open, 1'b0);
    wr_mode(4'hf, 8'h00);
    probe(1'b1);
  endtask
  // Tap 00 on the RC source: 512 ticks of eight cycles each
  task automatic t_timeout();
    int n;
    wdt_instr <= 1'b1;
    cyc(1);
    wdt_instr <= 1'b0;
    for (n = 0; n < 6000 && wdt_timeout !== 1'b1; n++) cyc(1);
    check((n >= 4080) && (n <= 4112), 1'b1);
    cyc(1);
    check(core_reset, 1'b1);
    wait_run();
    probe(1'b0);
  endtask
  task automatic t_vcc();
    vcc_low_pin <= 1'b1;
    cyc(4);
    check(core_reset, 1'b1);
    cyc(20);
    check(core_reset, 1'b1);
    vcc_low_pin <= 1'b0;
    wait_run();
  endtask
  // Time-base boot holds the core for the programmed span
  task automatic t_por_hold();
    cyc(20);
    check(hold_core_reset, 1'b1);
    cyc(1);
    check(hold_core_reset, 1'b0);
  endtask
  // Activity bits off freeze the count; tap 11 runs after release
  task automatic t_gating();
    int n;
    logic seen;
    seen = 1'b0;
    wr_mode(4'hf, 8'h03);
    halt_mode <= 1'b1;
    wdt_instr <= 1'b1;
    cyc(1);
    wdt_instr <= 1'b0;
    for (n = 0; n < 100; n++) begin
      seen = seen | wdt_timeout;
      cyc(1);
    end
    check(seen, 1'b0);
    halt_mode <= 1'b0;
    stop_mode <= 1'b1;
    for (n = 0; n < 100; n++) begin
      seen = seen | wdt_timeout;
      cyc(1);
    end
    check(seen, 1'b0);
    stop_mode <= 1'b0;
    for (n = 0; n < 1000 && wdt_timeout !== 1'b1; n++) cyc(1);
    check((n >= 792) && (n <= 808), 1'b1);
    wait_run();
  endtask
  // Reset defaults keep counting in halt and stop on tap 01
  task automatic t_defaults();
    int n;
    halt_mode <= 1'b1;
    stop_mode <= 1'b1;
    wdt_instr <= 1'b1;
    cyc(1);
    wdt_instr <= 1'b0;
    for (n = 0; n < 300 && wdt_timeout !== 1'b1; n++) cyc(1);
    check((n >= 112) && (n <= 128), 1'b1);
    check(rc_only_in_stop, 1'b0);
    halt_mode <= 1'b0;
    stop_mode <= 1'b0;
    wait_run();
    // A stop wake mid-count must recover from a cleared chain
    wdt_instr <= 1'b1;
    cyc(1);
    wdt_instr <= 1'b0;
    cyc(24);
    stop_wake <= 1'b1;
    cyc(1);
    stop_wake <= 1'b0;
    cyc(1);
    check(core_reset, 1'b1);
    for (n = 0; n < 100 && core_reset !== 1'b0; n++) cyc(1);
    check((n >= 32) && (n <= 42), 1'b1);
  endtask
  initial begin
    cyc(10);
    rst <= 1'b0;
    t_por_hold();
    t_window();
    t_lock();
    t_timeout();
    t_vcc();
    t_gating();
    t_defaults();
    stop_test();
  end
  // Hang guard well beyond the longest scenario
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end
endmodule // wdm_top_tb
`default_nettype wire
